/* File: hw/ddc_pkg.sv */
// constants, encodings and state types of the command decoder
// assumes a single 50 MHz clock domain; no file depends on import
package ddc_pkg;
    localparam int NBANK = 8;
    localparam int BA_W = 3;
    localparam int ADDR_W = 13;
    localparam int COL_W = 10;
    localparam int AP_BIT = 10;
    localparam int NMODE = 4;
    localparam int BURST_LEN_DEF = 4;
    localparam int CNT_W = 3;
    localparam logic [ADDR_W-1:0] MODE_RST = 13'h0000;
    // mode register select values on the low bank-address bits
    localparam logic [1:0] SEL_MR = 2'h0;
    localparam logic [1:0] SEL_EMR1 = 2'h1;
    localparam logic [1:0] SEL_EMR2 = 2'h2;
    localparam logic [1:0] SEL_EMR3 = 2'h3;
    // {ras_n, cas_n, we_n} encodings
    localparam logic [2:0] ENC_LMR = 3'h0;
    localparam logic [2:0] ENC_REF = 3'h1;
    localparam logic [2:0] ENC_PRE = 3'h2;
    localparam logic [2:0] ENC_ACT = 3'h3;
    localparam logic [2:0] ENC_WR = 3'h4;
    localparam logic [2:0] ENC_RD = 3'h5;
    localparam logic [2:0] ENC_NOP = 3'h7;

    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_NOP = 4'h1,
        CMD_DESEL = 4'h2,
        CMD_LMR = 4'h3,
        CMD_REF = 4'h4,
        CMD_SREF_IN = 4'h5,
        CMD_SREF_OUT = 4'h6,
        CMD_PD_IN = 4'h7,
        CMD_PD_OUT = 4'h8,
        CMD_ACT = 4'h9,
        CMD_PRE = 4'ha,
        CMD_PREA = 4'hb,
        CMD_WR = 4'hc,
        CMD_WRA = 4'hd,
        CMD_RD = 4'he,
        CMD_RDA = 4'hf
    } ddc_cmd_t;

    typedef enum logic [1:0] {
        PWR_ACTIVE = 2'h0,
        PWR_DOWN = 2'h1,
        PWR_SREF = 2'h2
    } ddc_pwr_t;
endpackage

/* File: hw/ddc_bank_if.sv */
// row open and close requests from the decoder to the bank slices
// assumes act, pre and ap_pre are single-cycle strobes in the clk_sys_in domain
`timescale 1ns/1ps
`default_nettype none
interface ddc_bank_if;
    logic act;
    logic pre;
    logic pre_all;
    logic ap_pre;
    logic [ddc_pkg::BA_W-1:0] bank;
    logic [ddc_pkg::BA_W-1:0] ap_bank;
    logic [ddc_pkg::ADDR_W-1:0] row;
    modport ctrl (output act, pre, pre_all, ap_pre, bank, ap_bank, row);
    modport slice (input act, pre, pre_all, ap_pre, bank, ap_bank, row);
endinterface
`default_nettype wire

/* File: hw/ddc_bank.sv */
// one bank: open flag and the row held open
// assumes requests arrive already accepted by the decoder
`timescale 1ns/1ps
`default_nettype none
module ddc_bank #(
    parameter logic [ddc_pkg::BA_W-1:0] IDX = 3'h0
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    ddc_bank_if.slice cmd,
    output logic open_out,
    output logic [ddc_pkg::ADDR_W-1:0] row_out
);
    wire hit_act = cmd.act && (cmd.bank == IDX);
    wire hit_pre = (cmd.pre && (cmd.pre_all || cmd.bank == IDX)) || (cmd.ap_pre && cmd.ap_bank == IDX);

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            open_out <= 1'b0;
            row_out <= ddc_pkg::MODE_RST;
        end else if (hit_act) begin
            open_out <= 1'b1;
            row_out <= cmd.row;
        end else if (hit_pre) begin
            open_out <= 1'b0;
        end
    end
endmodule // ddc_bank
`default_nettype wire

/* File: hw/ddc_cmd_decoder.sv */
// command decoder of a multi-bank ddr2 memory: power states, mode registers, bank rows
// assumes command pins are synchronous to clk_sys_in and held valid at its rising edge
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - all command pins and cke are taken only at the rising clock edge.
// - load mode: all strobes low, cke high twice; bank bits pick register.
// - bank bits 00,01,10,11 select main, first, second, third mode register.
// - refresh encoding with cke falling enters self refresh; cke rising exits.
// - cke low with nop or deselect enters power-down; cke high with nop or deselect leaves.
// - nop is registered and leaves running operations untouched.
// - chip select high ignores other pins; running operations continue.
// - decoding ignores termination input; termination off during self refresh.
// - bursts of four are never cut short by a later command.
// - activate opens the addressed row in the bank until precharged.
// - read takes bank, start column from low address, bit ten auto precharge.
// - auto precharge closes the row after the burst; otherwise it stays open.
// - read: cs low, ras high, cas low, we high; bit ten picks variant.
// - write with auto precharge: cs, cas, we low, ras high, bit ten high.
// - precharge bit ten high closes all banks, low only the named bank.
module ddc_cmd_decoder #(
    parameter int BURST_LEN = ddc_pkg::BURST_LEN_DEF
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic cke_in,
    input wire logic cs_n_in,
    input wire logic ras_n_in,
    input wire logic cas_n_in,
    input wire logic we_n_in,
    input wire logic [ddc_pkg::BA_W-1:0] ba_in,
    input wire logic [ddc_pkg::ADDR_W-1:0] addr_in,
    input wire logic odt_in,
    output ddc_pkg::ddc_cmd_t cmd_out,
    output logic cmd_valid_out,
    output logic [ddc_pkg::BA_W-1:0] bank_out,
    output logic [ddc_pkg::ADDR_W-1:0] addr_out,
    output logic auto_pre_out,
    output logic err_out,
    output ddc_pkg::ddc_pwr_t pwr_state_out,
    output logic odt_on_out,
    output logic burst_busy_out,
    output logic [ddc_pkg::NBANK-1:0] bank_open_out,
    output logic [ddc_pkg::NBANK*ddc_pkg::ADDR_W-1:0] bank_rows_out,
    output logic [ddc_pkg::ADDR_W-1:0] mode_main_out,
    output logic [ddc_pkg::ADDR_W-1:0] mode_ext1_out,
    output logic [ddc_pkg::ADDR_W-1:0] mode_ext2_out,
    output logic [ddc_pkg::ADDR_W-1:0] mode_ext3_out
);
    localparam logic [ddc_pkg::CNT_W-1:0] BURST_LOAD = ddc_pkg::CNT_W'(BURST_LEN / 2 - 1);

    generate
        if (BURST_LEN != 4 && BURST_LEN != 8) begin : g_bl_check
            $error("BURST_LEN must be 4 or 8");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic cke_prev;
    ddc_pkg::ddc_pwr_t pwr;
    logic [ddc_pkg::CNT_W-1:0] burst_cnt;
    logic [ddc_pkg::BA_W-1:0] burst_bank;
    logic burst_ap;
    logic [ddc_pkg::ADDR_W-1:0] mode_reg [ddc_pkg::NMODE];
    logic [ddc_pkg::NBANK-1:0] open_vec;
    logic [ddc_pkg::ADDR_W-1:0] row_vec [ddc_pkg::NBANK];

    ////////////////////////////////////////////////////////////////////////////
    // decode; odt_in takes no part in it
    wire [2:0] rcw = {ras_n_in, cas_n_in, we_n_in};
    wire a10 = addr_in[ddc_pkg::AP_BIT];
    wire idle_enc = cs_n_in || (rcw == ddc_pkg::ENC_NOP);
    wire sref_enc = !cs_n_in && (rcw == ddc_pkg::ENC_REF);
    wire busy = (burst_cnt != '0);

    ddc_pkg::ddc_cmd_t sel_cmd;
    ddc_pkg::ddc_cmd_t dec_cmd;
    assign sel_cmd = (rcw == ddc_pkg::ENC_LMR) ? ddc_pkg::CMD_LMR :
                     (rcw == ddc_pkg::ENC_REF) ? ddc_pkg::CMD_REF :
                     (rcw == ddc_pkg::ENC_PRE) ? (a10 ? ddc_pkg::CMD_PREA : ddc_pkg::CMD_PRE) :
                     (rcw == ddc_pkg::ENC_ACT) ? ddc_pkg::CMD_ACT :
                     (rcw == ddc_pkg::ENC_WR) ? (a10 ? ddc_pkg::CMD_WRA : ddc_pkg::CMD_WR) :
                     (rcw == ddc_pkg::ENC_RD) ? (a10 ? ddc_pkg::CMD_RDA : ddc_pkg::CMD_RD) :
                     (rcw == ddc_pkg::ENC_NOP) ? ddc_pkg::CMD_NOP : ddc_pkg::CMD_NONE;
    // self refresh exit needs no command decode: cke alone ends it
    assign dec_cmd = (pwr == ddc_pkg::PWR_SREF) ? (cke_in ? ddc_pkg::CMD_SREF_OUT : ddc_pkg::CMD_NONE) :
                     (pwr == ddc_pkg::PWR_DOWN) ? ((cke_in && idle_enc) ? ddc_pkg::CMD_PD_OUT : ddc_pkg::CMD_NONE) :
                     (!cke_prev) ? ddc_pkg::CMD_NONE :
                     (!cke_in) ? (sref_enc ? ddc_pkg::CMD_SREF_IN :
                                  idle_enc ? ddc_pkg::CMD_PD_IN : ddc_pkg::CMD_NONE) :
                     cs_n_in ? ddc_pkg::CMD_DESEL : sel_cmd;

    wire is_col = (dec_cmd == ddc_pkg::CMD_RD) || (dec_cmd == ddc_pkg::CMD_RDA) ||
                  (dec_cmd == ddc_pkg::CMD_WR) || (dec_cmd == ddc_pkg::CMD_WRA);
    wire is_pre = (dec_cmd == ddc_pkg::CMD_PRE) || (dec_cmd == ddc_pkg::CMD_PREA);
    wire is_act = (dec_cmd == ddc_pkg::CMD_ACT);
    // a running burst may not be cut: refuse column and precharge commands that would
    wire col_ok = is_col && !busy && open_vec[ba_in];
    wire pre_ok = is_pre && !(busy && (a10 || ba_in == burst_bank));
    wire act_ok = is_act && !open_vec[ba_in];
    wire refused = (is_col && !col_ok) || (is_pre && !pre_ok) || (is_act && !act_ok);
    wire ap_fire = burst_ap && (burst_cnt == ddc_pkg::CNT_W'(1));
    wire lmr_go = (dec_cmd == ddc_pkg::CMD_LMR);

    ddc_pkg::ddc_pwr_t next_pwr;
    assign next_pwr = (dec_cmd == ddc_pkg::CMD_SREF_IN) ? ddc_pkg::PWR_SREF :
                      (dec_cmd == ddc_pkg::CMD_PD_IN) ? ddc_pkg::PWR_DOWN :
                      (dec_cmd == ddc_pkg::CMD_SREF_OUT || dec_cmd == ddc_pkg::CMD_PD_OUT) ?
                      ddc_pkg::PWR_ACTIVE : pwr;

    ////////////////////////////////////////////////////////////////////////////
    // bank slices
    ddc_bank_if bif ();
    assign bif.act = act_ok;
    assign bif.pre = pre_ok;
    assign bif.pre_all = a10;
    assign bif.bank = ba_in;
    assign bif.row = addr_in;
    assign bif.ap_pre = ap_fire;
    assign bif.ap_bank = burst_bank;

    genvar gi;
    generate
        for (gi = 0; gi < ddc_pkg::NBANK; gi++) begin : g_bank
            ddc_bank #(.IDX(ddc_pkg::BA_W'(gi))) u_bank (
                .clk_sys_in(clk_sys_in),
                .nrst_in(nrst_in),
                .cmd(bif.slice),
                .open_out(open_vec[gi]),
                .row_out(row_vec[gi])
            );
        end
    endgenerate

    // one process owns the whole row vector, so no bit has two drivers
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bank_rows_out <= '0;
        end else begin
            for (int i = 0; i < ddc_pkg::NBANK; i++) begin
                bank_rows_out[i*ddc_pkg::ADDR_W +: ddc_pkg::ADDR_W] <= row_vec[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cke_prev <= 1'b0;
            pwr <= ddc_pkg::PWR_ACTIVE;
            cmd_out <= ddc_pkg::CMD_NONE;
            cmd_valid_out <= 1'b0;
            bank_out <= '0;
            addr_out <= ddc_pkg::MODE_RST;
            auto_pre_out <= 1'b0;
            err_out <= 1'b0;
            odt_on_out <= 1'b0;
            bank_open_out <= '0;
        end else begin
            cke_prev <= cke_in;
            pwr <= next_pwr;
            cmd_out <= dec_cmd;
            cmd_valid_out <= (dec_cmd != ddc_pkg::CMD_NONE);
            bank_out <= ba_in;
            addr_out <= addr_in;
            auto_pre_out <= is_col && a10;
            err_out <= refused;
            odt_on_out <= odt_in && (next_pwr != ddc_pkg::PWR_SREF);
            bank_open_out <= open_vec;
        end
    end

    // counter runs on through nop and deselect
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            burst_cnt <= '0;
            burst_bank <= '0;
            burst_ap <= 1'b0;
        end else if (col_ok) begin
            burst_cnt <= BURST_LOAD;
            burst_bank <= ba_in;
            burst_ap <= a10;
        end else if (busy) begin
            burst_cnt <= burst_cnt - ddc_pkg::CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < ddc_pkg::NMODE; i++) begin
                mode_reg[i] <= ddc_pkg::MODE_RST;
            end
        end else if (lmr_go) begin
            mode_reg[ba_in[1:0]] <= addr_in;
        end
    end

    assign burst_busy_out = busy;
    assign pwr_state_out = pwr;
    assign mode_main_out = mode_reg[ddc_pkg::SEL_MR];
    assign mode_ext1_out = mode_reg[ddc_pkg::SEL_EMR1];
    assign mode_ext2_out = mode_reg[ddc_pkg::SEL_EMR2];
    assign mode_ext3_out = mode_reg[ddc_pkg::SEL_EMR3];

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    property p_lmr;
        lmr_go |=> cmd_out == ddc_pkg::CMD_LMR && mode_reg[$past(ba_in[1:0])] == $past(addr_in);
    endproperty
    a_lmr: assert property (p_lmr) else $error("mode load not stored");

    property p_desel;
        pwr == ddc_pkg::PWR_ACTIVE && cke_prev && cke_in && cs_n_in
            |=> cmd_out == ddc_pkg::CMD_DESEL && !err_out
                && burst_cnt == $past(burst_cnt) - ddc_pkg::CNT_W'($past(busy));
    endproperty
    a_desel: assert property (p_desel) else $error("deselect disturbed state");

    property p_nop;
        pwr == ddc_pkg::PWR_ACTIVE && cke_prev && cke_in && !cs_n_in && rcw == ddc_pkg::ENC_NOP
            |=> cmd_out == ddc_pkg::CMD_NOP && $stable(mode_main_out);
    endproperty
    a_nop: assert property (p_nop) else $error("nop misdecoded");

    property p_act;
        act_ok |-> ##2 bank_open_out[$past(ba_in, 2)] && bank_rows_out[$past(ba_in, 2)*ddc_pkg::ADDR_W +: ddc_pkg::ADDR_W] == $past(addr_in, 2);
    endproperty
    a_act: assert property (p_act) else $error("activate did not open row");

    property p_prea;
        pre_ok && a10 && !act_ok |-> ##2 bank_open_out == '0;
    endproperty
    a_prea: assert property (p_prea) else $error("precharge all left a bank open");

    property p_sref;
        pwr == ddc_pkg::PWR_ACTIVE && cke_prev && !cke_in && sref_enc
            |=> pwr_state_out == ddc_pkg::PWR_SREF ##1 ($past(cke_in) || pwr_state_out == ddc_pkg::PWR_SREF);
    endproperty
    a_sref: assert property (p_sref) else $error("self refresh entry wrong");

    property p_sref_exit;
        pwr == ddc_pkg::PWR_SREF && cke_in |=> pwr_state_out == ddc_pkg::PWR_ACTIVE && cmd_out == ddc_pkg::CMD_SREF_OUT;
    endproperty
    a_sref_exit: assert property (p_sref_exit) else $error("self refresh exit wrong");

    property p_pd;
        pwr == ddc_pkg::PWR_ACTIVE && cke_prev && !cke_in && idle_enc |=> pwr_state_out == ddc_pkg::PWR_DOWN;
    endproperty
    a_pd: assert property (p_pd) else $error("power-down entry wrong");

    property p_odt;
        pwr_state_out == ddc_pkg::PWR_SREF |-> !odt_on_out;
    endproperty
    a_odt: assert property (p_odt) else $error("termination on in self refresh");

    property p_noint;
        busy && is_col |=> err_out && $past(burst_bank) == burst_bank;
    endproperty
    a_noint: assert property (p_noint) else $error("burst cut short");

    property p_rd;
        col_ok && rcw == ddc_pkg::ENC_RD
            |=> cmd_out == ($past(a10) ? ddc_pkg::CMD_RDA : ddc_pkg::CMD_RD) && auto_pre_out == $past(a10)
                && addr_out[ddc_pkg::COL_W-1:0] == $past(addr_in[ddc_pkg::COL_W-1:0]);
    endproperty
    a_rd: assert property (p_rd) else $error("read misdecoded");

    property p_ap;
        col_ok && a10 && BURST_LEN == 4 |-> ##3 !bank_open_out[$past(ba_in, 3)];
    endproperty
    a_ap: assert property (p_ap) else $error("auto precharge missing");

    property p_pre_one;
        pre_ok && !a10 |-> ##2 !bank_open_out[$past(ba_in, 2)];
    endproperty
    a_pre_one: assert property (p_pre_one) else $error("bank precharge left row open");

    property p_burst;
        col_ok |=> burst_busy_out && cmd_out != ddc_pkg::CMD_NONE && bank_out == $past(ba_in);
    endproperty
    a_burst: assert property (p_burst) else $error("column command not started");

    property p_act_refuse;
        is_act && !act_ok |=> err_out && row_vec[$past(ba_in)] == $past(row_vec[ba_in]);
    endproperty
    a_act_refuse: assert property (p_act_refuse) else $error("open row overwritten");

    property p_pd_exit;
        pwr == ddc_pkg::PWR_DOWN && cke_in && idle_enc
            |=> pwr_state_out == ddc_pkg::PWR_ACTIVE && cmd_out == ddc_pkg::CMD_PD_OUT;
    endproperty
    a_pd_exit: assert property (p_pd_exit) else $error("power-down exit wrong");

    c_lmr: cover property (lmr_go);
    c_sref: cover property (dec_cmd == ddc_pkg::CMD_SREF_IN ##[1:50] dec_cmd == ddc_pkg::CMD_SREF_OUT);
    c_pd: cover property (dec_cmd == ddc_pkg::CMD_PD_IN);
    c_rda: cover property (act_ok ##[1:20] col_ok && a10);
    c_ref: cover property (dec_cmd == ddc_pkg::CMD_REF);
endmodule // ddc_cmd_decoder
`default_nettype wire

/* File: testbench/ddc_ctrl_model.sv */
// memory controller model: drives command, bank, address, cke and odt pins
// assumes callers ask for one command per clock; pins change at falling edges
`timescale 1ns/1ps
`default_nettype none
module ddc_ctrl_model (
    input wire logic clk_sys_in,
    output logic cke_out,
    output logic cs_n_out,
    output logic [2:0] enc_out,
    output logic [ddc_pkg::BA_W-1:0] ba_out,
    output logic [ddc_pkg::ADDR_W-1:0] addr_out,
    output logic odt_out
);
    // every pin, don't-care ones too, starts at a defined level
    initial begin
        cke_out = 1'b1;
        cs_n_out = 1'b1;
        enc_out = ddc_pkg::ENC_NOP;
        ba_out = '0;
        addr_out = '0;
        odt_out = 1'b0;
    end
    // pins change off the rising edge and hold through it
    task automatic cmd(input logic c, input logic cs, input logic [2:0] e, input logic [2:0] b, input logic [12:0] a);
        @(negedge clk_sys_in);
        cke_out = c;
        cs_n_out = cs;
        enc_out = e;
        ba_out = b;
        addr_out = a;
    endtask
    // idle cycle: don't-care pins toggle yet stay defined
    // callers space commands with these; timing minimums are theirs
    task automatic nop();
        cmd(1'b1, 1'b0, ddc_pkg::ENC_NOP, ~ba_out, ~addr_out);
    endtask
    task automatic odt(input logic v);
        @(negedge clk_sys_in);
        odt_out = v;
    endtask
endmodule // ddc_ctrl_model
`default_nettype wire

/* File: testbench/ddr2_command_decoder_tb.sv */
// self-checking bench of the command decoder, one task a scenario
// assumes ddc_ctrl_model drives the pins; outputs are read at falling edges
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_count++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module ddr2_command_decoder_tb;
    logic clk_sys_in = 1'b0;
    logic nrst_in = 1'b0;
    int err_count = 0;
    int checks = 0;
    wire logic cke, cs_n, odt;
    wire logic [2:0] enc, ba;
    wire logic [12:0] addr;
    ddc_pkg::ddc_cmd_t cmd;
    ddc_pkg::ddc_pwr_t pwr;
    logic ap, err, odt_on, busy, valid;
    logic [2:0] bank_o;
    logic [12:0] addr_o, m0, m1, m2, m3;
    logic [7:0] open;
    logic [103:0] rows;
    always #10 clk_sys_in = ~clk_sys_in;
    ddc_ctrl_model m (.clk_sys_in(clk_sys_in), .cke_out(cke), .cs_n_out(cs_n), .enc_out(enc), .ba_out(ba),
        .addr_out(addr), .odt_out(odt));
    ddc_cmd_decoder #(.BURST_LEN(4)) dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .cke_in(cke),
        .cs_n_in(cs_n), .ras_n_in(enc[2]), .cas_n_in(enc[1]), .we_n_in(enc[0]), .ba_in(ba), .addr_in(addr),
        .odt_in(odt), .cmd_out(cmd), .cmd_valid_out(valid), .bank_out(bank_o), .addr_out(addr_o), .auto_pre_out(ap),
        .err_out(err), .pwr_state_out(pwr), .odt_on_out(odt_on), .burst_busy_out(busy), .bank_open_out(open),
        .bank_rows_out(rows), .mode_main_out(m0), .mode_ext1_out(m1), .mode_ext2_out(m2), .mode_ext3_out(m3));
    ////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (err_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic go(input logic c, input logic cs, input logic [2:0] e, input logic [2:0] b, input logic [12:0] a);
        m.cmd(c, cs, e, b, a);
        m.nop();
    endtask
    task automatic wait_n(input int n);
        repeat (n) m.nop();
    endtask
    task automatic open_bank(input logic [2:0] b, input logic [12:0] r);
        go(1'b1, 1'b0, ddc_pkg::ENC_ACT, b, r);
        wait_n(2);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_lmr();
        for (int i = 0; i < 4; i++) begin
            go(1'b1, 1'b0, ddc_pkg::ENC_LMR, {i[0], i[1:0]}, 13'h0a5 + 13'h111 * i[12:0]);
            `CHK("lmr", ddc_pkg::CMD_LMR, cmd)
            wait_n(1);
        end
        `CHK("mr0", 13'h0a5, m0)
        `CHK("mr1", 13'h1b6, m1)
        `CHK("mr2", 13'h2c7, m2)
        `CHK("mr3", 13'h3d8, m3)
    endtask
    task automatic t_act();
        go(1'b1, 1'b0, ddc_pkg::ENC_ACT, 3'h2, 13'h1234);
        `CHK("act", ddc_pkg::CMD_ACT, cmd)
        m.nop();
        `CHK("open2", 1'b1, open[2])
        `CHK("row2", 13'h1234, rows[26 +: 13])
        go(1'b1, 1'b0, ddc_pkg::ENC_ACT, 3'h2, 13'h0fff);
        `CHK("act_err", 1'b1, err)
        wait_n(2);
        `CHK("row2_kept", 13'h1234, rows[26 +: 13])
    endtask
    task automatic t_col(input logic [2:0] e, input logic a10, input logic [2:0] b, input ddc_pkg::ddc_cmd_t x);
        go(1'b1, 1'b0, e, b, {2'h0, a10, 10'h3f0});
        `CHK("col", x, cmd)
        `CHK("ap", a10, ap)
        `CHK("busy", 1'b1, busy)
        `CHK("bank", b, bank_o)
        `CHK("col_addr", 10'h3f0, addr_o[9:0])
        wait_n(3);
        `CHK("ap_close", ~a10, open[b])
    endtask
    task automatic t_b2b();
        open_bank(3'h4, 13'h0044);
        m.cmd(1'b1, 1'b0, ddc_pkg::ENC_RD, 3'h4, 13'h0000);
        go(1'b1, 1'b0, ddc_pkg::ENC_RD, 3'h4, 13'h0400);
        `CHK("b2b_cmd", ddc_pkg::CMD_RDA, cmd)
        `CHK("b2b_err", 1'b1, err)
        wait_n(3);
        `CHK("b2b_open", 1'b1, open[4])
    endtask
    task automatic t_pre();
        open_bank(3'h5, 13'h0055);
        go(1'b1, 1'b0, ddc_pkg::ENC_PRE, 3'h4, 13'h0000);
        `CHK("pre", ddc_pkg::CMD_PRE, cmd)
        m.nop();
        `CHK("pre_one", 8'h20, open)
        open_bank(3'h1, 13'h0011);
        go(1'b1, 1'b0, ddc_pkg::ENC_PRE, 3'h1, 13'h0400);
        `CHK("prea", ddc_pkg::CMD_PREA, cmd)
        m.nop();
        `CHK("pre_all", 8'h00, open)
    endtask
    task automatic t_idle();
        open_bank(3'h6, 13'h0066);
        go(1'b1, 1'b1, ddc_pkg::ENC_PRE, 3'h6, 13'h0400);
        `CHK("desel", ddc_pkg::CMD_DESEL, cmd)
        m.nop();
        `CHK("desel_open", 8'h40, open)
        go(1'b1, 1'b0, ddc_pkg::ENC_REF, 3'h0, 13'h0000);
        `CHK("ref", ddc_pkg::CMD_REF, cmd)
        `CHK("ref_valid", 1'b1, valid)
        `CHK("ref_err", 1'b0, err)
        m.cmd(1'b1, 1'b0, ddc_pkg::ENC_RD, 3'h6, 13'h0400);
        go(1'b1, 1'b0, ddc_pkg::ENC_NOP, 3'h6, 13'h0400);
        `CHK("nop", ddc_pkg::CMD_NOP, cmd)
        m.nop();
        `CHK("nop_ap", 8'h00, open)
    endtask
    task automatic t_pwr();
        m.odt(1'b1);
        open_bank(3'h7, 13'h0077);
        `CHK("odt_on", 1'b1, odt_on)
        `CHK("odt_act", 8'h80, open)
        m.cmd(1'b0, 1'b0, ddc_pkg::ENC_NOP, 3'h0, 13'h0000);
        m.cmd(1'b0, 1'b1, ddc_pkg::ENC_NOP, 3'h0, 13'h0000);
        `CHK("pd_in", ddc_pkg::CMD_PD_IN, cmd)
        `CHK("pd", ddc_pkg::PWR_DOWN, pwr)
        go(1'b1, 1'b1, ddc_pkg::ENC_NOP, 3'h0, 13'h0000);
        `CHK("pd_out", ddc_pkg::CMD_PD_OUT, cmd)
        `CHK("pd_act", ddc_pkg::PWR_ACTIVE, pwr)
        m.cmd(1'b0, 1'b0, ddc_pkg::ENC_REF, 3'h0, 13'h0000);
        m.cmd(1'b0, 1'b0, ddc_pkg::ENC_ACT, 3'h0, 13'h0000);
        `CHK("sr", ddc_pkg::PWR_SREF, pwr)
        `CHK("sr_odt", 1'b0, odt_on)
        go(1'b1, 1'b0, ddc_pkg::ENC_NOP, 3'h1, 13'h0000);
        `CHK("sr_out", ddc_pkg::CMD_SREF_OUT, cmd)
        `CHK("sr_act", ddc_pkg::PWR_ACTIVE, pwr)
        m.odt(1'b0);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(negedge clk_sys_in);
        `CHK("rst_cmd", ddc_pkg::CMD_NONE, cmd)
        `CHK("rst_valid", 1'b0, valid)
        `CHK("rst_mode", 52'h0, {m0, m1, m2, m3})
        @(negedge clk_sys_in);
        nrst_in = 1'b1;
        m.nop();
        t_lmr();
        t_act();
        t_col(ddc_pkg::ENC_RD, 1'b0, 3'h2, ddc_pkg::CMD_RD);
        t_col(ddc_pkg::ENC_RD, 1'b1, 3'h2, ddc_pkg::CMD_RDA);
        open_bank(3'h3, 13'h0033);
        t_col(ddc_pkg::ENC_WR, 1'b0, 3'h3, ddc_pkg::CMD_WR);
        t_col(ddc_pkg::ENC_WR, 1'b1, 3'h3, ddc_pkg::CMD_WRA);
        t_b2b();
        t_pre();
        t_idle();
        t_pwr();
        close_out();
    end
    initial begin
        #100us;
        err_count++;
        close_out();
    end
endmodule // ddr2_command_decoder_tb
`default_nettype wire
